// ==== verilog/sap_pkg.sv ====
// Package for the serial audio port: register map, fields, reset values.
// Assumes a single 250 MHz system clock; link pins are sampled synchronously.
package sap_pkg;
  // Register byte offsets (one 32-bit word each)
  localparam logic [7:0] SAP_CTRL_OFS = 8'h00;
  localparam logic [7:0] SAP_LIMIT_OFS = 8'h04;
  localparam logic [7:0] SAP_STATUS_OFS = 8'h08;
  localparam logic [7:0] SAP_TXDATA_OFS = 8'h0c;
  localparam logic [7:0] SAP_RXDATA_OFS = 8'h10;
  localparam logic [7:0] SAP_PRESC_OFS = 8'h14;
  // Control field positions
  localparam int SAP_EN_BIT = 0;
  localparam int SAP_SYNC_BIT = 1;
  localparam int SAP_WORD16_BIT = 2;
  localparam int SAP_GEN_BIT = 3;
  localparam int SAP_RXDMA_BIT = 4;
  localparam int SAP_TXDMA_BIT = 5;
  localparam int SAP_IRQEN_BIT = 6;
  localparam int SAP_SLOTS_LSB = 8;
  // Warning limit fields
  localparam int SAP_RXLIM_LSB = 0;
  localparam int SAP_TXLIM_LSB = 8;
  // Reset values
  localparam logic [31:0] SAP_CTRL_RST = 32'h0000_0000;
  localparam logic [4:0] SAP_RXLIM_RST = 5'h07;
  localparam logic [4:0] SAP_TXLIM_RST = 5'h08;
  localparam logic [7:0] SAP_PRESC_RST = 8'h3f;
  // Last bit index of an internally generated frame; sync pulses once per 32 bit periods
  localparam logic [4:0] SAP_FRAME_BITS = 5'h1f;
  // Word lengths
  localparam logic [4:0] SAP_LEN8 = 5'h08;
  localparam logic [4:0] SAP_LEN16 = 5'h10;

  typedef enum logic [1:0] {
    SAP_IDLE = 2'b00,
    SAP_SHIFT = 2'b01,
    SAP_TAIL = 2'b10
  } sap_tx_state_t;

  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sap_apb_req_t;

  // Pin pair (output and enable) for a two-way pin
  typedef struct packed {
    logic o;
    logic oe;
  } sap_pin_out_t;
endpackage

// ==== verilog/sap_fifo.sv ====
// Flip-flop FIFO used for the receive and transmit word buffers.
// Writes when full and reads when empty are ignored by the FIFO itself.
`timescale 1ns/1ps
module sap_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write side
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic rd_en,
  output logic [WIDTH-1:0] rd_data,
  // Fill level
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] next_count;
  logic do_wr, do_rd;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be power of 2");
  end

  // Pointer and level update; full and empty guard the strobes
  always_comb begin
    do_wr = wr_en && (count != (AW+1)'(DEPTH));
    do_rd = rd_en && (count != '0);
    next_wp = do_wr ? wp + 1'b1 : wp;
    next_rp = do_rd ? rp + 1'b1 : rp;
    next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      count <= next_count;
    end
  end

  // Storage carries no reset to stay a plain register array
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp] <= wr_data;
    end
  end

  assign rd_data = mem[rp];
endmodule

// ==== verilog/sap_port.sv ====
// Serial audio port: APB registers, bit clock and frame sync generation,
// transmit and receive shifters, FIFOs and DMA holding registers.
// Assumes link pins are synchronous to clk (edges are detected on clk).
`timescale 1ns/1ps
module sap_port
  import sap_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int WORD_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire sap_pkg::sap_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit link
  input wire logic tx_clk_i,
  output sap_pkg::sap_pin_out_t tx_clk_out,
  input wire logic tx_frame_sync_i,
  output sap_pkg::sap_pin_out_t tx_frame_sync_out,
  output sap_pkg::sap_pin_out_t tx_serial_data,
  // Receive link
  input wire logic rx_serial_data,
  input wire logic rx_shift_clock_i,
  output sap_pkg::sap_pin_out_t rx_shift_clock_out,
  input wire logic rx_frame_sync_i,
  output sap_pkg::sap_pin_out_t rx_frame_sync_out,
  // Requests
  output logic irq,
  output logic rx_dma_req,
  output logic tx_dma_req
);
  import sap_pkg::*;
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  initial begin
    if (FIFO_DEPTH != 16 || WORD_W != 16) $error("Port serves 16x16 only");
  end

  // Software state
  logic [31:0] ctrl, next_ctrl;
  logic [4:0] rx_limit, tx_limit, next_rx_limit, next_tx_limit;
  logic [7:0] presc, next_presc;
  logic [15:0] tx_dma_holding_0, next_txh;
  logic txh_full, next_txh_full;
  logic [15:0] rx_dma_holding_0, next_rxh;
  logic rxh_full, next_rxh_full;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  // Decoded controls
  logic en, sync_mode, word16, gen, rx_dma, tx_dma, irq_en;
  logic [4:0] wlen;
  // Clock generation
  logic [7:0] div_cnt, next_div_cnt;
  logic bclk, next_bclk;
  logic [4:0] fbit, next_fbit;
  logic fs_gen, next_fs_gen;
  // Edge detection of link clocks and syncs
  logic txc_d, rxc_d, txfs_d, rxfs_d;
  logic txc_now, rxc_now, txfs_now, rxfs_now;
  logic tx_rise, tx_fall, rx_fall, tfs_rise, rfs_rise;
  // Transmit path
  sap_tx_state_t tx_st, next_tx_st;
  logic [15:0] tx_shift_register, next_tsr;
  logic [4:0] tx_bits, next_tx_bits;
  logic tx_pend, next_tx_pend;
  logic txd_o, txd_oe, next_txd_o, next_txd_oe;
  // Receive path
  logic [15:0] rx_shift_register, next_rsr;
  logic [4:0] rx_bits, next_rx_bits;
  logic rx_act, next_rx_act;
  logic rx_done;
  logic [15:0] rx_word;
  // FIFO hooks
  logic rxf_wr, rxf_rd, txf_wr, txf_rd;
  logic [15:0] rxf_q, txf_q;
  logic [CW-1:0] rxf_cnt, txf_cnt;
  logic next_irq, next_rx_dma_req, next_tx_dma_req, next_drv;
  logic wr_acc, rd_acc;
  logic [15:0] tx_word;
  logic tx_avail, tx_load;

  assign en = ctrl[SAP_EN_BIT];
  // Generating clocks forces the shared-clock mode
  assign gen = ctrl[SAP_GEN_BIT];
  assign sync_mode = ctrl[SAP_SYNC_BIT] | gen;
  assign word16 = ctrl[SAP_WORD16_BIT];
  assign wlen = word16 ? SAP_LEN16 : SAP_LEN8;
  assign rx_dma = ctrl[SAP_RXDMA_BIT];
  assign tx_dma = ctrl[SAP_TXDMA_BIT];
  assign irq_en = ctrl[SAP_IRQEN_BIT];

  // Receive FIFO and transmit FIFO
  sap_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(clk), .rst(rst), .wr_en(rxf_wr), .wr_data(rx_word),
    .rd_en(rxf_rd), .rd_data(rxf_q), .count(rxf_cnt));
  sap_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(clk), .rst(rst), .wr_en(txf_wr), .wr_data(apb_req.pwdata[15:0]),
    .rd_en(txf_rd), .rd_data(txf_q), .count(txf_cnt));

  // APB decode: one-cycle wait, answer registered
  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite &&
    !pready;
  assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite &&
    !pready;
  assign txf_wr = wr_acc && (apb_req.paddr == SAP_TXDATA_OFS) && !tx_dma;
  assign rxf_rd = rd_acc && (apb_req.paddr == SAP_RXDATA_OFS) && !rx_dma;

  // Link edge view; the selected clock depends on mode and generation
  always_comb begin
    txc_now = gen ? bclk : tx_clk_i;
    txfs_now = gen ? fs_gen : tx_frame_sync_i;
    rxc_now = sync_mode ? txc_now : rx_shift_clock_i;
    rxfs_now = sync_mode ? txfs_now : rx_frame_sync_i;
    tx_rise = en && txc_now && !txc_d;
    tx_fall = en && !txc_now && txc_d;
    rx_fall = en && !rxc_now && rxc_d;
    tfs_rise = txfs_now && !txfs_d;
    rfs_rise = rxfs_now && !rxfs_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txc_d <= 1'b0;
      rxc_d <= 1'b0;
      txfs_d <= 1'b0;
      rxfs_d <= 1'b0;
    end else begin
      txc_d <= txc_now;
      rxc_d <= rxc_now;
      txfs_d <= txfs_now;
      rxfs_d <= rxfs_now;
    end
  end

  // Bit clock divider: free-running while enabled and generating, held at zero otherwise
  always_comb begin
    next_div_cnt = div_cnt;
    next_bclk = bclk;
    next_fbit = fbit;
    next_fs_gen = fs_gen;
    if (!en || !gen) begin
      next_div_cnt = '0;
      next_bclk = 1'b0;
      next_fbit = '0;
      next_fs_gen = 1'b0;
    end else if (div_cnt == presc) begin
      next_div_cnt = '0;
      next_bclk = !bclk;
      // Sync is set up on falling edge so the partner sees it at rising
      if (bclk) begin
        next_fbit = fbit + 5'h01;
        next_fs_gen = (fbit == SAP_FRAME_BITS);
      end
    end else begin
      next_div_cnt = div_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
      bclk <= 1'b0;
      fbit <= '0;
      fs_gen <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      bclk <= next_bclk;
      fbit <= next_fbit;
      fs_gen <= next_fs_gen;
    end
  end

  // Transmit source: holding register under DMA, else FIFO
  assign tx_avail = tx_dma ? txh_full : (txf_cnt != '0);
  assign tx_word = tx_dma ? tx_dma_holding_0 : txf_q;
  assign tx_load = tx_rise && tx_pend && tx_avail;
  assign txf_rd = tx_load && !tx_dma;

  // Transmit shifter; one word per frame
  always_comb begin
    next_tx_st = tx_st;
    next_tsr = tx_shift_register;
    next_tx_bits = tx_bits;
    next_tx_pend = tx_pend || (en && tfs_rise);
    next_txd_o = txd_o;
    next_txd_oe = txd_oe;
    if (!en) begin
      next_tx_st = SAP_IDLE;
      next_tx_pend = 1'b0;
      next_txd_oe = 1'b0;
    end else if (tx_load) begin
      next_tx_st = SAP_SHIFT;
      next_tx_pend = 1'b0;
      next_tsr = word16 ? tx_word : {tx_word[7:0], 8'h00};
      next_tx_bits = wlen - 5'h01;
      next_txd_o = word16 ? tx_word[15] : tx_word[7];
      next_txd_oe = 1'b1;
      if (!word16) next_tsr = {tx_word[6:0], 9'h000};
      else next_tsr = {tx_word[14:0], 1'b0};
    end else if (tx_rise && tx_st == SAP_SHIFT && tx_bits != '0) begin
      next_txd_o = tx_shift_register[15];
      next_tsr = {tx_shift_register[14:0], 1'b0};
      next_tx_bits = tx_bits - 5'h01;
    end else if (tx_fall && tx_st == SAP_SHIFT && tx_bits == '0) begin
      // Last bit: hold drive if the next word starts at once
      next_tx_st = SAP_TAIL;
      next_txd_oe = tx_pend && tx_avail;
    end else if (tx_rise && tx_st == SAP_TAIL) begin
      next_tx_st = SAP_IDLE;
      next_txd_oe = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st <= SAP_IDLE;
      tx_shift_register <= '0;
      tx_bits <= '0;
      tx_pend <= 1'b0;
      txd_o <= 1'b0;
      txd_oe <= 1'b0;
    end else begin
      tx_st <= next_tx_st;
      tx_shift_register <= next_tsr;
      tx_bits <= next_tx_bits;
      tx_pend <= next_tx_pend;
      txd_o <= next_txd_o;
      txd_oe <= next_txd_oe;
    end
  end

  // Receive shifter: counts valid bits only after a sync rise
  // The finished word includes the bit sampled on this very edge
  assign rx_word = {rx_shift_register[14:0], rx_serial_data};
  assign rx_done = rx_fall && rx_act && (rx_bits == wlen - 5'h01);
  assign rxf_wr = rx_done && !rx_dma;
  always_comb begin
    next_rsr = rx_shift_register;
    next_rx_bits = rx_bits;
    next_rx_act = rx_act;
    if (!en) begin
      next_rx_act = 1'b0;
      next_rx_bits = '0;
    end else begin
      if (rfs_rise) begin
        next_rx_act = 1'b1;
        next_rx_bits = '0;
      end
      if (rx_fall && (rx_act || rfs_rise)) begin
        next_rsr = {rx_shift_register[14:0], rx_serial_data};
        next_rx_bits = rfs_rise ? 5'h01 : rx_bits + 5'h01;
        if (!rfs_rise && rx_bits == wlen - 5'h01) begin
          next_rx_act = 1'b0;
          next_rx_bits = '0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_shift_register <= '0;
      rx_bits <= '0;
      rx_act <= 1'b0;
    end else begin
      rx_shift_register <= next_rsr;
      rx_bits <= next_rx_bits;
      rx_act <= next_rx_act;
    end
  end

  // Register file, holding registers and bus answer
  always_comb begin
    next_ctrl = ctrl;
    next_rx_limit = rx_limit;
    next_tx_limit = tx_limit;
    next_presc = presc;
    next_txh = tx_dma_holding_0;
    next_txh_full = txh_full && !(tx_load && tx_dma);
    next_rxh = rx_dma_holding_0;
    next_rxh_full = rxh_full;
    next_prdata = '0;
    next_pready = apb_req.psel && apb_req.penable && !pready;
    next_pslverr = 1'b0;
    if (wr_acc) begin
      unique case (apb_req.paddr)
        SAP_CTRL_OFS: next_ctrl = apb_req.pwdata;
        SAP_LIMIT_OFS: begin
          next_rx_limit = apb_req.pwdata[SAP_RXLIM_LSB +: 5];
          next_tx_limit = apb_req.pwdata[SAP_TXLIM_LSB +: 5];
        end
        SAP_PRESC_OFS: next_presc = apb_req.pwdata[7:0];
        SAP_TXDATA_OFS: if (tx_dma) begin
          next_txh = apb_req.pwdata[15:0];
          next_txh_full = 1'b1;
        end
        SAP_STATUS_OFS, SAP_RXDATA_OFS: ;
        default: next_pslverr = 1'b1;
      endcase
    end
    if (rd_acc) begin
      unique case (apb_req.paddr)
        SAP_CTRL_OFS: next_prdata = ctrl;
        SAP_LIMIT_OFS: next_prdata = {19'h0, tx_limit, 3'h0, rx_limit};
        SAP_PRESC_OFS: next_prdata = {24'h0, presc};
        SAP_STATUS_OFS: next_prdata = {6'h0, rxf_cnt, 3'h0, txf_cnt,
          11'h0, rxh_full, txh_full};
        SAP_RXDATA_OFS: begin
          next_prdata = {16'h0, rx_dma ? rx_dma_holding_0 : rxf_q};
          if (rx_dma) next_rxh_full = 1'b0;
        end
        SAP_TXDATA_OFS: next_prdata = '0;
        default: next_pslverr = 1'b1;
      endcase
    end
    // A word landing in the same cycle as the read keeps it full
    if (rx_done && rx_dma) begin
      next_rxh = rx_word;
      next_rxh_full = 1'b1;
    end
    next_rx_dma_req = rx_dma && next_rxh_full;
    next_tx_dma_req = tx_dma && !next_txh_full;
    // Clock and sync pins are driven only while generating them
    next_drv = next_ctrl[SAP_GEN_BIT] && next_ctrl[SAP_EN_BIT];
    next_irq = irq_en && en &&
      ((!rx_dma && rxf_cnt > CW'(rx_limit)) ||
       (!tx_dma && txf_cnt <= CW'(tx_limit)));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= SAP_CTRL_RST;
      rx_limit <= SAP_RXLIM_RST;
      tx_limit <= SAP_TXLIM_RST;
      presc <= SAP_PRESC_RST;
      tx_dma_holding_0 <= '0;
      txh_full <= 1'b0;
      rx_dma_holding_0 <= '0;
      rxh_full <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      rx_dma_req <= 1'b0;
      tx_dma_req <= 1'b0;
      tx_clk_out <= '0;
      tx_frame_sync_out <= '0;
      tx_serial_data <= '0;
      rx_shift_clock_out <= '0;
      rx_frame_sync_out <= '0;
    end else begin
      ctrl <= next_ctrl;
      rx_limit <= next_rx_limit;
      tx_limit <= next_tx_limit;
      presc <= next_presc;
      tx_dma_holding_0 <= next_txh;
      txh_full <= next_txh_full;
      rx_dma_holding_0 <= next_rxh;
      rxh_full <= next_rxh_full;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
      rx_dma_req <= next_rx_dma_req;
      tx_dma_req <= next_tx_dma_req;
      // Pins leave flops; receive pins stay inputs in shared-clock mode
      tx_clk_out <= '{o: next_bclk, oe: next_drv};
      tx_frame_sync_out <= '{o: next_fs_gen, oe: next_drv};
      tx_serial_data <= '{o: next_txd_o, oe: next_txd_oe};
      rx_shift_clock_out <= '0;
      rx_frame_sync_out <= '0;
    end
  end

endmodule

// ==== bench/sap_port_properties.sv ====
// Checker for the serial audio port: pin timing and bus relations.
// Assumes it is bound to sap_port and sees only its ports.
`timescale 1ns/1ps
module sap_port_properties
  import sap_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire sap_pkg::sap_apb_req_t apb_req,
  input wire logic pready,
  // Link pins
  input wire logic tx_clk_i,
  input wire sap_pkg::sap_pin_out_t tx_clk_out,
  input wire sap_pkg::sap_pin_out_t tx_frame_sync_out,
  input wire sap_pkg::sap_pin_out_t tx_serial_data,
  input wire sap_pkg::sap_pin_out_t rx_shift_clock_out,
  input wire sap_pkg::sap_pin_out_t rx_frame_sync_out,
  // Requests
  input wire logic irq,
  input wire logic rx_dma_req,
  input wire logic tx_dma_req
);
  logic bc;
  logic bc_d;
  logic [5:0] nf;
  logic [5:0] next_nf;
  logic [9:0] st;
  logic [9:0] next_st;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Bit clock on the wire, whoever drives it
  assign bc = tx_clk_out.oe ? tx_clk_out.o : tx_clk_i;
  // Falls per driven word; cycles without a generated clock edge
  always_comb begin
    next_nf = tx_serial_data.oe ? nf + {5'h00, bc_d & ~bc} : 6'h00;
    next_st = (tx_clk_out.oe && bc == bc_d) ? st + 10'h001 : 10'h000;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bc_d <= 1'b0;
      nf <= 6'h00;
      st <= 10'h000;
    end else begin
      bc_d <= bc;
      nf <= next_nf;
      st <= next_st;
    end
  end
  AST_RX_PINS_FREE:
    assert property (!rx_shift_clock_out.oe && !rx_frame_sync_out.oe)
    else $error("receive pin driven");
  AST_DATA_ON_RISE:
    assert property (tx_serial_data.oe && $past(tx_serial_data.oe) &&
      $changed(tx_serial_data.o) |-> bc) else $error("data moved, clock low");
  AST_WORD_LEN:
    assert property ($fell(tx_serial_data.oe) |-> nf == 6'h08 || nf == 6'h10)
    else $error("driven word length wrong");
  AST_CLK_RUNS:
    assert property (st <= 10'h100) else $error("generated clock stopped");
  AST_SYNC_WITH_CLK:
    assert property (tx_frame_sync_out.oe == tx_clk_out.oe)
    else $error("sync and clock drive differ");
  AST_RXDMA_HOLD:
    assert property (rx_dma_req && !apb_req.penable |=> rx_dma_req)
    else $error("receive request dropped");
  AST_TXDMA_HOLD:
    assert property (tx_dma_req && !apb_req.penable |=> tx_dma_req)
    else $error("transmit request dropped");
  AST_PREADY_PULSE:
    assert property (pready |-> $past(apb_req.psel) && $past(apb_req.penable)
      ##1 !pready) else $error("bad ready pulse");
  // Main scenarios reached
  cover property ($fell(tx_serial_data.oe));
  cover property ($rose(rx_dma_req));
  cover property ($rose(irq));
endmodule

// ==== bench/sap_codec_model.sv ====
// External codec model: supplies bit clock, both syncs and receive data.
// Assumes the bench pulses start for one cycle and waits while busy.
`timescale 1ns/1ps
module sap_codec_model
  import sap_pkg::*;
#(
  parameter int HALF = 4
) (
  // Clock
  input wire logic clk,
  // Frame request
  input wire logic start,
  input wire logic len16,
  input wire logic [15:0] word,
  output logic busy,
  // Link pins
  input wire sap_pkg::sap_pin_out_t tx_pin,
  output logic bclk,
  output logic sync,
  output logic sd,
  // Captured transmit word and bit count
  output logic [15:0] cap,
  output logic [4:0] nb
);
  // Clock stands still between frames; released data shows its inverse
  initial begin
    {busy, bclk, sync, sd, cap, nb} = '0;
    forever begin
      @(posedge clk);
      if (start) begin
        busy <= 1'b1;
        sync <= 1'b1;
        nb <= 5'h00;
        repeat (HALF) @(posedge clk);
        for (int i = len16 ? 15 : 7; i >= -2; i--) begin
          bclk <= 1'b1;
          sd <= (i >= 0) ? word[i] : ~word[0];
          repeat (HALF) @(posedge clk);
          bclk <= 1'b0;
          sync <= 1'b0;
          if (tx_pin.oe) begin
            cap <= {cap[14:0], tx_pin.o};
            nb <= nb + 5'h01;
          end
          repeat (HALF) @(posedge clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// ==== bench/test_codec_serial_audio_port.sv ====
// Bench for the serial audio port: APB tasks, codec model, frame tests.
// Assumes the package, the design and the codec model compile first.
`timescale 1ns/1ps
module test_codec_serial_audio_port;
  import sap_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx_on = 1'b1;
  logic start = 1'b0;
  logic len16 = 1'b0;
  logic [15:0] word = 16'h0000;
  sap_apb_req_t req = '0;
  sap_pin_out_t tco, tso, tsd, rco, rso;
  logic tci, tsi, rci, rsi, pready, pslverr, perr, irq, rxd, txd;
  logic busy, m_bclk, m_sync, m_sd;
  logic [31:0] prdata, got;
  logic [15:0] cap;
  logic [4:0] nb;
  int err_count = 0;
  int compares = 0;

  always #2 clk = ~clk;
  // A pin follows the design while it drives, else the codec
  assign tci = tco.oe ? tco.o : m_bclk;
  assign tsi = tso.oe ? tso.o : m_sync;
  assign rci = rco.oe ? rco.o : (rx_on & m_bclk);
  assign rsi = rso.oe ? rso.o : (rx_on & m_sync);

  sap_port dut (.clk(clk), .rst(rst), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_clk_i(tci), .tx_clk_out(tco),
    .tx_frame_sync_i(tsi), .tx_frame_sync_out(tso), .tx_serial_data(tsd),
    .rx_serial_data(m_sd), .rx_shift_clock_i(rci),
    .rx_shift_clock_out(rco), .rx_frame_sync_i(rsi),
    .rx_frame_sync_out(rso), .irq(irq), .rx_dma_req(rxd),
    .tx_dma_req(txd));
  sap_codec_model codec (.clk(clk), .start(start), .len16(len16),
    .word(word), .busy(busy), .tx_pin(tsd), .bclk(m_bclk), .sync(m_sync),
    .sd(m_sd), .cap(cap), .nb(nb));

  task automatic summarize();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      summarize();
    end
    got = prdata;
    perr = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, got & m);
  endtask

  // One codec frame; ends when the codec goes idle
  task automatic frame(input logic l16, input logic [15:0] w);
    int n;
    @(posedge clk);
    len16 <= l16;
    word <= w;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((busy !== 1'b0 || n < 2) && n < 2000);
    if (n >= 2000) begin
      err_count++;
      summarize();
    end
  endtask

  initial begin
    int rises;
    logic prev;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset values of control and limits and an unmapped place
    rd(SAP_CTRL_OFS, 32'hffff_ffff, SAP_CTRL_RST, "ctrl");
    rd(SAP_LIMIT_OFS, 32'h0000_1f1f,
      {19'h0, SAP_TXLIM_RST, 3'h0, SAP_RXLIM_RST}, "limit");
    apb(1'b0, 8'h18, 32'h0);
    chk("slverr", 32'h1, {31'h0, perr});
    // Asynchronous FIFO mode, 16-bit words, filled past its depth
    apb(1'b1, SAP_CTRL_OFS, 32'h0000_0045);
    repeat (3) @(posedge clk);
    chk("irq empty", 32'h1, {31'h0, irq});
    for (int i = 0; i < 20; i++) begin
      apb(1'b1, SAP_TXDATA_OFS, 32'h8100 + i);
    end
    rd(SAP_STATUS_OFS, 32'h0003_e000, 32'h0002_0000, "tx level");
    chk("irq full", 32'h0, {31'h0, irq});
    apb(1'b1, SAP_LIMIT_OFS, 32'h0000_0100);
    rd(SAP_LIMIT_OFS, 32'h0000_1f1f, 32'h0000_0100, "limit");
    frame(1'b1, 16'ha5c3);
    chk("tx word", 32'h8100, {16'h0, cap});
    chk("tx bits", 32'h10, {27'h0, nb});
    rd(SAP_STATUS_OFS, 32'h03e0_0000, 32'h0020_0000, "rx level");
    chk("irq rx", 32'h1, {31'h0, irq});
    rd(SAP_RXDATA_OFS, 32'h0000_ffff, 32'h0000_a5c3, "rx word");
    repeat (3) @(posedge clk);
    chk("irq drained", 32'h0, {31'h0, irq});
    // 8-bit words, one per frame
    apb(1'b1, SAP_CTRL_OFS, 32'h0000_0041);
    frame(1'b0, 16'h005a);
    chk("tx byte", 32'h01, {24'h0, cap[7:0]});
    chk("tx byte bits", 32'h8, {27'h0, nb});
    rd(SAP_RXDATA_OFS, 32'h0000_00ff, 32'h0000_005a, "rx byte");
    // Synchronous DMA mode, receive pins held still
    rx_on <= 1'b0;
    apb(1'b1, SAP_CTRL_OFS, 32'h0000_0037);
    repeat (3) @(posedge clk);
    chk("tx dma empty", 32'h1, {31'h0, txd});
    apb(1'b1, SAP_TXDATA_OFS, 32'h0000_6b2d);
    repeat (3) @(posedge clk);
    chk("tx dma loaded", 32'h0, {31'h0, txd});
    frame(1'b1, 16'h9e17);
    chk("tx dma word", 32'h6b2d, {16'h0, cap});
    chk("rx dma full", 32'h1, {31'h0, rxd});
    chk("tx dma again", 32'h1, {31'h0, txd});
    rd(SAP_STATUS_OFS, 32'h03e0_0002, 32'h0000_0002, "rx hold");
    rd(SAP_RXDATA_OFS, 32'h0000_ffff, 32'h0000_9e17, "rx dma");
    repeat (3) @(posedge clk);
    chk("rx dma read", 32'h0, {31'h0, rxd});
    // Internally generated clock and sync
    apb(1'b1, SAP_PRESC_OFS, 32'h0000_0003);
    apb(1'b1, SAP_CTRL_OFS, 32'h0000_000d);
    repeat (400) @(posedge clk);
    chk("gen drive", 32'h3, {30'h0, tco.oe, tso.oe});
    // Half period of four clocks gives ten rises in eighty cycles
    rises = 0;
    prev = tco.o;
    repeat (80) begin
      @(posedge clk);
      if (tco.o && !prev) rises++;
      prev = tco.o;
    end
    chk("bit clock rises", 32'h0000_000a, rises);
    chk("rx pins free", 32'h0, {30'h0, rco.oe, rso.oe});
    summarize();
  end
endmodule

bind sap_port sap_port_properties chk_props (.clk(clk), .rst(rst),
  .apb_req(apb_req), .pready(pready), .tx_clk_i(tx_clk_i),
  .tx_clk_out(tx_clk_out), .tx_frame_sync_out(tx_frame_sync_out),
  .tx_serial_data(tx_serial_data), .rx_shift_clock_out(rx_shift_clock_out),
  .rx_frame_sync_out(rx_frame_sync_out), .irq(irq),
  .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req));
